/* dce_defines.vh */
// dce_defines.vh: offsets, field positions, reset values and timing counts
// of the dual comparator event logic.
// assumes inclusion by bare name from a single design file.
`ifndef DCE_DEFINES_VH
`define DCE_DEFINES_VH

// register offsets (byte addresses on the plain register port)
`define DCE_ADDR_W           4
`define DCE_OFF_CMP1_CFG     4'h0
`define DCE_OFF_CMP2_CFG     4'h1
`define DCE_OFF_PWR_DIS      4'h2
`define DCE_OFF_PWR_MODE     4'h3

// comparator configuration field positions
`define DCE_CFG_EN           0
`define DCE_CFG_NEG_REF      1
`define DCE_CFG_PIN_OUT      2
`define DCE_CFG_IRQ_EN       3
`define DCE_CFG_RESULT       4
`define DCE_CFG_FLAG         5
`define DCE_CFG_WMASK        8'h0F
`define DCE_CFG_RST          4'h0

// peripheral power-disable register: comparator power-down bit
`define DCE_PWR_CMP_BIT      5
`define DCE_PWR_RST          8'h00

// power mode encodings
`define DCE_MODE_RUN         2'h0
`define DCE_MODE_IDLE        2'h1
`define DCE_MODE_PD          2'h2
`define DCE_MODE_TPD         2'h3

// settling time after enabling a comparator
`define DCE_SETTLE_NS        10000
`define DCE_CLK_NS           4
// settle ns over clock ns, sized to the 14-bit counter
`define DCE_SETTLE_CYC       14'h09C4

`endif

/* dce_comparator_events.v */
// dce_comparator_events.v: digital control and event logic for two analog
// comparators: gating, reference select, edge flags, shared interrupt.
// assumes comparator results are synchronous-looking levels from the analog
// front end and a plain register port driven on the same clock.
`include "dce_defines.vh"

module dce_comparator_events (
	input  wire                   i_mclk,
	input  wire                   i_rst,
	input  wire [`DCE_ADDR_W-1:0] i_addr,
	input  wire [7:0]             i_wdata,
	input  wire                   i_wr,
	input  wire                   i_rd,
	output reg  [7:0]             o_rdata,
	input  wire [1:0]             i_pwr_mode,
	input  wire [1:0]             i_cmp_result,
	output wire [1:0]             o_cmp_power,
	output wire [1:0]             o_cmp_neg_ref,
	output reg                    o_cmp1_pin,
	output wire                   o_cmp1_pin_oe,
	output wire [1:0]             o_cmp_settling,
	output wire                   o_irq,
	output wire                   o_wake
);

	localparam [13:0] SETTLE_CYC = `DCE_SETTLE_CYC;

	reg  [3:0]  cfg1;
	reg  [3:0]  cfg2;
	reg  [7:0]  pwr_dis;
	reg  [1:0]  sync_a;
	reg  [1:0]  sync_b;
	reg  [1:0]  prev;
	reg  [1:0]  flag;
	reg  [1:0]  prev_on;
	reg  [13:0] settle1;
	reg  [13:0] settle2;
	reg  [7:0]  next_rdata;
	wire [1:0]  cmp_on;
	wire [1:0]  result;
	wire [1:0]  change;
	wire [1:0]  irq_en;
	wire        tpd;
	wire        clr1;
	wire        clr2;
	reg  [1:0]  on_d1;
	reg  [1:0]  on_d2;

	// pack one configuration register for readback
	function [7:0] cfg_word;
		input [3:0] cfg;
		input       res;
		input       flg;
		begin
			cfg_word = {2'h0, flg, res, cfg};
		end
	endfunction

	// settle counter step: load on enable, count down, stop at zero
	function [13:0] settle_next;
		input        turn_on;
		input [13:0] cnt;
		begin
			if (turn_on)
				settle_next = SETTLE_CYC;
			else if (cnt != 14'h0000)
				settle_next = cnt - 14'h0001;
			else
				settle_next = cnt;
		end
	endfunction

	// write strobe aimed at one offset; used by the flag clear only, storage decodes i_addr in its own case
	function wr_hit;
		input                   wr;
		input [`DCE_ADDR_W-1:0] addr;
		input [`DCE_ADDR_W-1:0] target;
		begin
			wr_hit = wr && (addr == target);
		end
	endfunction

	// one flag step: a change outranks a clear in the same cycle
	function flag_next;
		input chg;
		input clr;
		input cur;
		begin
			if (chg)
				flag_next = 1'b1;
			else if (clr)
				flag_next = 1'b0;
			else
				flag_next = cur;
		end
	endfunction

	// power gating: total power-down or the disable bit overrides enables
	assign tpd = (i_pwr_mode == `DCE_MODE_TPD);
	assign cmp_on[0] = cfg1[`DCE_CFG_EN] & ~tpd
		& ~pwr_dis[`DCE_PWR_CMP_BIT];
	assign cmp_on[1] = cfg2[`DCE_CFG_EN] & ~tpd
		& ~pwr_dis[`DCE_PWR_CMP_BIT];
	assign o_cmp_power = cmp_on;
	assign o_cmp_neg_ref = {cfg2[`DCE_CFG_NEG_REF],
		cfg1[`DCE_CFG_NEG_REF]};

	// power-valid pipeline as deep as the synchroniser; junk from an
	// unpowered front end must not reach the edge logic as a change
	always @(posedge i_mclk) begin
		if (i_rst) begin
			on_d1 <= 2'h0;
			on_d2 <= 2'h0;
		end else begin
			on_d1 <= cmp_on;
			on_d2 <= on_d1 & cmp_on;
		end
	end

	// a powered-off comparator reads zero, never a stale high
	assign result = sync_b & cmp_on & on_d2;
	assign change = result ^ prev;

	// settling status for firmware, which must hold off the interrupt
	assign o_cmp_settling = {settle2 != 14'h0000,
		settle1 != 14'h0000};

	// shared interrupt, masked off in total power-down
	assign irq_en = {cfg2[`DCE_CFG_IRQ_EN], cfg1[`DCE_CFG_IRQ_EN]};
	assign o_irq = |(flag & irq_en) & ~tpd;
	assign o_wake = o_irq;

	// result pin follows comparator 1 when routed
	assign o_cmp1_pin_oe = cfg1[`DCE_CFG_PIN_OUT];

	// two-stage synchroniser; only sync_b feeds the edge logic
	always @(posedge i_mclk) begin
		if (i_rst) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			prev   <= 2'h0;
		end else begin
			sync_a <= i_cmp_result;
			sync_b <= sync_a;
			prev   <= result;
		end
	end

	// configuration registers, writable bits only
	always @(posedge i_mclk) begin
		if (i_rst) begin
			cfg1    <= `DCE_CFG_RST;
			cfg2    <= `DCE_CFG_RST;
			pwr_dis <= `DCE_PWR_RST;
		end else if (i_wr) begin
			case (i_addr)
				`DCE_OFF_CMP1_CFG: cfg1 <= i_wdata[3:0];
				`DCE_OFF_CMP2_CFG: cfg2 <= i_wdata[3:0];
				`DCE_OFF_PWR_DIS:  pwr_dis <= i_wdata;
				default: ;
			endcase
		end
	end

	// clear requests: a configuration write with the flag bit low
	assign clr1 = wr_hit(i_wr, i_addr, `DCE_OFF_CMP1_CFG)
		& ~i_wdata[`DCE_CFG_FLAG];
	assign clr2 = wr_hit(i_wr, i_addr, `DCE_OFF_CMP2_CFG)
		& ~i_wdata[`DCE_CFG_FLAG];

	// sticky change flags; a change in the clear cycle wins
	always @(posedge i_mclk) begin
		if (i_rst) begin
			flag <= 2'h0;
		end else begin
			flag[0] <= flag_next(change[0], clr1, flag[0]);
			flag[1] <= flag_next(change[1], clr2, flag[1]);
		end
	end

	// last cycle's power, so a rising enable can be spotted
	always @(posedge i_mclk) begin
		if (i_rst)
			prev_on <= 2'h0;
		else
			prev_on <= cmp_on;
	end

	// comparator 1 settle window restarts on each power-up
	always @(posedge i_mclk) begin
		if (i_rst)
			settle1 <= 14'h0000;
		else
			settle1 <= settle_next(cmp_on[0] & ~prev_on[0], settle1);
	end

	// comparator 2 settle window; status only, irq is not held off
	always @(posedge i_mclk) begin
		if (i_rst)
			settle2 <= 14'h0000;
		else
			settle2 <= settle_next(cmp_on[1] & ~prev_on[1], settle2);
	end

	// registered pin output; low while the comparator is off
	always @(posedge i_mclk) begin
		if (i_rst)
			o_cmp1_pin <= 1'b0;
		else
			o_cmp1_pin <= result[0] & cfg1[`DCE_CFG_PIN_OUT];
	end

	// read mux, unmapped offsets read zero
	always @* begin
		case (i_addr)
			`DCE_OFF_CMP1_CFG: next_rdata = cfg_word(cfg1, result[0],
				flag[0]);
			`DCE_OFF_CMP2_CFG: next_rdata = cfg_word(cfg2, result[1],
				flag[1]);
			`DCE_OFF_PWR_DIS:  next_rdata = pwr_dis;
			`DCE_OFF_PWR_MODE: next_rdata = {6'h00, i_pwr_mode};
			default:           next_rdata = 8'h00;
		endcase
	end

	// read data stands in the cycle after the strobe only
	always @(posedge i_mclk) begin
		if (i_rst)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= next_rdata;
		else
			o_rdata <= 8'h00;
	end

endmodule

/* dce_asserts.sv */
// checker: port-level timing of the comparator event block
// assumes bind onto dce_comparator_events, single clock domain
module dce_asserts (
	input wire       i_mclk, i_rst, i_wr, i_rd,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata, o_rdata,
	input wire [1:0] i_pwr_mode, o_cmp_power, o_cmp_neg_ref, o_cmp_settling,
	input wire       o_cmp1_pin_oe, o_irq, o_wake
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// wake follows the shared request; power gating and register effects
	wake_irq_a: assert property (o_wake == o_irq)
		else $error("wake differs from irq");
	tpd_off_a: assert property (i_pwr_mode == 2'h3 |->
		o_cmp_power == 2'h0 && !o_irq) else $error("active in tpd");
	pwr_dis_a: assert property (i_wr && i_addr == 4'h2 && i_wdata[5] |=>
		o_cmp_power == 2'h0) else $error("power bit ignored");
	neg_sel_a: assert property (i_wr && i_addr == 4'h1 |=>
		o_cmp_neg_ref[1] == $past(i_wdata[1])) else $error("ref select");
	pin_oe_a: assert property (i_wr && i_addr == 4'h0 |=>
		o_cmp1_pin_oe == $past(i_wdata[2])) else $error("pin enable");
	settle_on_a: assert property ($rose(o_cmp_power[0]) |->
		##[0:1] o_cmp_settling[0]) else $error("no settle window");
	mode_rd_a: assert property (i_rd && i_addr == 4'h3 |=>
		o_rdata == {6'h00, $past(i_pwr_mode)}) else $error("mode readback");
	rd_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("stray read data");
endmodule

/* dce_front_model.sv */
// analog front end: two comparators, negative input from pin or reference
// assumes millivolt levels from the bench; unpowered outputs are garbage
module dce_front_model #(
	parameter int DLY = 1
) (
	input  wire [1:0]       i_power, i_neg_ref,
	input  wire [1:0][11:0] i_pos, i_pin,
	output wire [1:0]       o_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tgl = 1'h0;
	// toggling so a gated-off front end never looks settled
	always #4 tgl = ~tgl;
	for (genvar c = 0; c < 2; c++) begin : g_cmp
		// reference is 1230 mV; ties read as zero
		assign #(DLY) o_result[c] = !i_power[c] ? tgl :
			i_pos[c] > (i_neg_ref[c] ? 12'h4CE : i_pin[c]);
	end
endmodule

/* testbench.sv */
// testbench: random analog levels, power modes, flag polling and clearing
// assumes the design, its header and the front end model are compiled
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
	error_cnt++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, dis = 1'h0;
	logic [3:0]       i_addr = 4'h0;
	logic [7:0]       i_wdata = 8'h00;
	logic [1:0]       i_pwr_mode = 2'h0, res = 2'h0, flg = 2'h0, n;
	logic [1:0][11:0] pos = '0, pin = '0;
	logic [3:0]       cfg [2] = '{4'h7, 4'h5};
	wire  [1:0]       i_cmp_result, o_cmp_power, o_cmp_neg_ref, o_cmp_settling;
	wire  [7:0]       o_rdata;
	wire              o_cmp1_pin, o_cmp1_pin_oe, o_irq, o_wake;
	int               error_cnt = 0, n_compared = 0;
	dce_comparator_events uut (.*);
	dce_front_model fe (.i_power(o_cmp_power), .i_neg_ref(o_cmp_neg_ref),
		.i_pos(pos), .i_pin(pin), .o_result(i_cmp_result));
	always #2 i_mclk = ~i_mclk;
	// expected power gate of one comparator
	function automatic logic on(int c);
		return cfg[c][0] && !dis && i_pwr_mode != 2'h3;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_mclk);
		i_wr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_mclk);
		i_rd <= 1'h0;
		#1 `CHK(o_rdata, e)
	endtask
	// let two sync stages pass, then update and compare the model
	task automatic settle();
		repeat (6) @(posedge i_mclk);
		for (int c = 0; c < 2; c++)
			n[c] = on(c) && pos[c] > (cfg[c][1] ? 12'h4CE : pin[c]);
		flg |= n ^ res;
		res = n;
		#1 `CHK(o_cmp_power, {on(1), on(0)})
		`CHK(o_irq, |(flg & {cfg[1][3], cfg[0][3]}) && i_pwr_mode != 2'h3)
		if (cfg[0][2]) `CHK(o_cmp1_pin, res[0])
		rd(4'h0, {2'h0, flg[0], res[0], cfg[0]});
		rd(4'h1, {2'h0, flg[1], res[1], cfg[1]});
		rd(4'h3, {6'h00, i_pwr_mode});
	endtask
	task automatic clr(int c);
		wr(4'(c), {4'h0, cfg[c]});
		flg[c] = 1'h0;
	endtask
	task automatic finish_test();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000 error_cnt++;
		finish_test();
	end
	initial begin
		void'($urandom(10111));
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'h0;
		rd(4'h2, 8'h00);
		wr(4'h3, 8'hFF);
		wr(4'hF, 8'hFF);
		rd(4'h9, 8'h00);
		wr(4'h0, 8'h07);
		wr(4'h1, 8'h05);
		repeat (2600) @(posedge i_mclk); // firmware waits out settling
		settle();
		clr(0);
		clr(1);
		cfg = '{4'hF, 4'hD};
		wr(4'h0, 8'h0F);
		wr(4'h1, 8'h0D);
		for (int i = 0; i < 40; i++) begin
			pos <= {12'($urandom % 2500), 12'($urandom % 2500)};
			pin <= {12'($urandom % 2500), 12'h000};
			dis = ($urandom % 6) == 0;
			wr(4'h2, {2'h0, dis, 5'h00});
			settle();
			i_pwr_mode <= 2'($urandom % 4);
			settle();
			if (i % 3 == 0)
				clr(i % 2);
		end
		finish_test();
	end
endmodule
bind dce_comparator_events dce_asserts chk (.*);
